// >>> inc/mlrb_defs.vh
// Constants for the local register bank: address map, window limits, counter layout
`ifndef MLRB_DEFS_VH
`define MLRB_DEFS_VH
`define MLRB_LOCAL_INDEX     8'h00ff
`define MLRB_MBOX_FIRST      12'h0001
`define MLRB_MBOX_LAST       12'h0800
`define MLRB_RACK_LAST       12'h0040
`define MLRB_INREG_BASE      12'h0020
`define MLRB_INREG_LAST      12'h0020
`define MLRB_STAT_FIRST      12'h0801
`define MLRB_STAT_LAST       12'h0820
`define MLRB_CNT_LAST        12'h0816
`define MLRB_RSVD_FIRST      12'h0817
`define MLRB_RSVD_LAST       12'h081b
`define MLRB_ROUTE_FIRST     12'h081c
`define MLRB_ROUTE_LAST      12'h081f
`define MLRB_BUFUSE          12'h0820
// One number per statistics word 0x801..0x81f, in register order
`define MLRB_ETH_CMD_REPLY_RX_COUNT     12'h0801
`define MLRB_ETH_RX_NO_BUFFER_COUNT     12'h0802
`define MLRB_ETH_RETRY_RX_COUNT         12'h0803
`define MLRB_ETH_LOCAL_GEN_COUNT        12'h0804
`define MLRB_ETH_GEN_FAIL_COUNT         12'h0805
`define MLRB_ETH_TX_OK_COUNT            12'h0806
`define MLRB_ETH_TX_FAIL_COUNT          12'h0807
`define MLRB_ETH_TX_RETRY_COUNT         12'h0808
`define MLRB_ETH_BAD_ROUTE_COUNT        12'h0809
`define MLRB_ETH_ILLEGAL_OP_COUNT       12'h080a
`define MLRB_ETH_PRIO_READ_COUNT        12'h080b
`define MLRB_ETH_PRIO_WRITE_COUNT       12'h080c
`define MLRB_ETH_NONPRIO_READ_COUNT     12'h080d
`define MLRB_ETH_NONPRIO_WRITE_COUNT    12'h080e
`define MLRB_ETH_FOREIGN_PKT_RX_COUNT   12'h080f
`define MLRB_ETH_PKT_TX_COUNT           12'h0810
`define MLRB_ETH_PKT_RX_COUNT           12'h0811
`define MLRB_ETH_COLLISION_COUNT        12'h0812
`define MLRB_ETH_EXCESS_COLLISION_COUNT 12'h0813
`define MLRB_ETH_CRC_ERROR_COUNT        12'h0814
`define MLRB_ETH_FRAMING_ERROR_COUNT    12'h0815
`define MLRB_ETH_SEQ_NAK_COUNT          12'h0816
`define MLRB_ETH_RESERVED_A             12'h0817
`define MLRB_ETH_RESERVED_B             12'h0818
`define MLRB_ETH_RESERVED_C             12'h0819
`define MLRB_ETH_RESERVED_D             12'h081a
`define MLRB_ETH_RESERVED_E             12'h081b
`define MLRB_ETH_LAST_ROUTE_DROPS_1_2   12'h081c
`define MLRB_ETH_LAST_ROUTE_DROPS_3_4   12'h081d
`define MLRB_ETH_LAST_ROUTE_DROPS_5_6   12'h081e
`define MLRB_ETH_LAST_ROUTE_DROPS_7_8   12'h081f
`define MLRB_NUM_EVENTS      22
`define MLRB_CNT_RESET       16'h0000
`endif

// >>> verilog/mlrb_event_counter.v
// One 16-bit wrapping event counter that software clears by writing zero
`timescale 1ns/1ps
module mlrb_event_counter (
  input  wire        ref_clk_in,
  input  wire        srst_in,
  input  wire        inc_in,
  input  wire        clr_in,
  input  wire        load_in,
  input  wire [15:0] load_data_in,
  output reg  [15:0] count_out
);
`include "mlrb_defs.vh"
  // An increment in the same cycle as a clear leaves the count at one so no event is lost
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      count_out <= `MLRB_CNT_RESET;
    end else if (clr_in) begin
      count_out <= inc_in ? 16'h0001 : `MLRB_CNT_RESET; // [R08]
    end else if (load_in) begin
      count_out <= load_data_in + {15'h0000, inc_in};
    end else if (inc_in) begin
      count_out <= count_out + 16'h0001; // Wraps from ffff to zero [R21]
    end
  end
endmodule

// >>> verilog/mlrb_register_bank.v
// Local register bank: mailbox, rack window and Ethernet statistics group
//
// What this block does
// (R01) Messages with index 255 address local registers; others are routed onward.
// (R02) I/O module rack-addresses registers 1..64 only; option module rack-addresses none.
// (R03) PLC reaches all other registers through master message blocks or scanner.
// (R04) 2048 mailbox registers, numbered 1..2048, read and writable from Ethernet.
// (R05) Mailbox 33..64 also appear to the PLC as input registers 1..32.
// (R06) Rack start address maps to mailbox 1, then ascending.
// (R07) Mailbox outside rack window stays accessible but is not scanned by PLC.
// (R08) 32 Ethernet statistics registers; writing zero clears a register. Only counters 0x801..0x816 clear; writes to 0x81c..0x820 are refused.
// (R09) 2049..2051 count commands/replies, no-buffer drops, retry packets.
// (R10) 2052..2056 count generations, generation failures, tx ok, tx fail, retries.
// (R11) 2057 counts packets lost to bad drop or bad route.
// (R12) 2058 counts illegal operations on local registers.
// (R13) 2059..2062 count priority and non-priority reads and writes.
// (R14) 2063..2065 count foreign packets, all transmitted, all received.
// (R15) 2066 counts collisions, 2067 excess-collision abandons.
// (R16) 2068 counts CRC errors, 2069 framing errors.
// (R17) 2070 counts sequence negative acknowledges sent.
// (R18) 2076..2079 hold last received route, two drops each, drops 1..8.
// (R19) 2080 reports message buffers in use.
// (R20) 2071..2075 reserved; read as zero, writes ignored.
// (R21) Counters are 16 bits and wrap to zero.
//
// Interface summary
// Either port may carry a request every cycle; each answer stands for one cycle.
// Network side: exactly one of ack, error or route follows each request.
// Read data rides with the ack and is zero for writes and refusals.
// Rack side: ack or error follows each request, read data with the ack.
// One mailbox word is written per cycle; a network mailbox write drops any rack write in that cycle.
// Event inputs are one-cycle pulses, bit k feeding register 0x801 plus k.
// Limitations
// Mailbox words have no reset value; write one before trusting a read of it.
// The input window is read-only; option-module mode refuses every rack access.
// Routed requests are answered here but counted by the router, not this bank.
// A nonzero counter write presets the count, so software can check the wrap.
// An event in the same cycle as a counter write is still counted.
// Address map by register number
//   0x001..0x800 mailbox; 0x801..0x816 event counters
//   0x817..0x81b reserved; 0x81c..0x820 route and buffer status
//   Any other number is refused and counted as an illegal operation
`timescale 1ns/1ps
module mlrb_register_bank (
  input  wire        ref_clk_in,
  input  wire        srst_in,
  // Network message port
  input  wire        msg_valid_in,
  input  wire [7:0]  msg_index_in,
  input  wire        msg_write_in,
  input  wire        msg_priority_in,
  input  wire [11:0] msg_addr_in,
  input  wire [15:0] msg_wdata_in,
  output reg         msg_ack_out,
  output reg         msg_err_out,
  output reg         msg_route_out,
  output reg  [15:0] msg_rdata_out,
  // PLC rack scan port
  input  wire        io_module_mode_in,
  input  wire        rack_valid_in,
  input  wire        rack_write_in,
  input  wire        rack_input_space_in,
  input  wire [11:0] rack_offset_in,
  input  wire [15:0] rack_wdata_in,
  output reg         rack_ack_out,
  output reg         rack_err_out,
  output reg  [15:0] rack_rdata_out,
  // Ethernet port events and state
  input  wire [21:0] stat_event_in,
  input  wire        route_valid_in,
  input  wire [63:0] route_drops_in,
  input  wire [15:0] buffers_in_use_in
);
`include "mlrb_defs.vh"

  // ==========================================================================
  // Address helpers
  // ==========================================================================
  // True for a mailbox register number 1..2048
  function is_mbox;
    input [11:0] a;
    begin
      is_mbox = (a >= `MLRB_MBOX_FIRST) && (a <= `MLRB_MBOX_LAST);
    end
  endfunction

  // True for a register number inside the statistics group
  function is_stat;
    input [11:0] a;
    begin
      is_stat = (a >= `MLRB_STAT_FIRST) && (a <= `MLRB_STAT_LAST);
    end
  endfunction

  // Mailbox array index for a register number 1..2048
  function [10:0] mbox_idx;
    input [11:0] a;
    reg   [11:0] t;
    begin
      t        = a - `MLRB_MBOX_FIRST;
      mbox_idx = t[10:0];
    end
  endfunction

  // ==========================================================================
  // Storage
  // ==========================================================================
  reg  [15:0] mbox_mem [0:2047];
  reg  [15:0] route_reg [0:3];
  reg  [15:0] bufuse_reg;
  wire [15:0] cnt_val [0:21];

  // ==========================================================================
  // Request decode
  // ==========================================================================
  // Only index 255 is local; anything else goes to the router [R01]
  wire        msg_local   = msg_valid_in && (msg_index_in == `MLRB_LOCAL_INDEX); // [R01]
  wire        msg_mbox    = msg_local && is_mbox(msg_addr_in); // [R04]
  wire        msg_stat    = msg_local && is_stat(msg_addr_in);
  wire        msg_cnt     = msg_stat && (msg_addr_in <= `MLRB_CNT_LAST);
  wire        msg_rsvd    = msg_stat && (msg_addr_in >= `MLRB_RSVD_FIRST) && (msg_addr_in <= `MLRB_RSVD_LAST);
  wire        msg_ro      = msg_stat && (msg_addr_in >= `MLRB_ROUTE_FIRST);
  // Writing a read-only status word or an unmapped number is illegal
  wire        msg_illegal = msg_local && !(msg_mbox || msg_cnt || msg_rsvd || (msg_ro && !msg_write_in));
  wire [11:0] cnt_off12   = msg_addr_in - `MLRB_STAT_FIRST;
  wire [4:0]  cnt_sel     = cnt_off12[4:0];

  // Rack window: offset 0 is mailbox 1; input space shifts by 32 [R05] [R06]
  wire [11:0] rack_reg_no = rack_offset_in + `MLRB_MBOX_FIRST + (rack_input_space_in ? `MLRB_INREG_BASE : 12'h0000);
  wire        rack_in_rng = rack_input_space_in ? (rack_offset_in < `MLRB_INREG_LAST) && !rack_write_in
                                                : (rack_offset_in < `MLRB_RACK_LAST);
  // Option modules expose no rack window at all [R02]; beyond 64 is not scanned [R07]
  wire        rack_hit    = rack_valid_in && io_module_mode_in && rack_in_rng; // [R02]

  // Local request events that feed the statistics counters
  wire ev_prio_rd   = msg_local && !msg_illegal && !msg_write_in && msg_priority_in;  // [R13]
  wire ev_prio_wr   = msg_local && !msg_illegal && msg_write_in && msg_priority_in;   // [R13]
  wire ev_nprio_rd  = msg_local && !msg_illegal && !msg_write_in && !msg_priority_in; // [R13]
  wire ev_nprio_wr  = msg_local && !msg_illegal && msg_write_in && !msg_priority_in;  // [R13]

  // ==========================================================================
  // Counter event vector: positions follow register numbers 2049..2070
  // ==========================================================================
  reg [21:0] cnt_inc;
  always @* begin
    cnt_inc     = stat_event_in;                    // [R09] [R10] [R11] [R14] [R15] [R16] [R17]
    cnt_inc[9]  = stat_event_in[9] | msg_illegal;   // [R12]
    cnt_inc[10] = stat_event_in[10] | ev_prio_rd;
    cnt_inc[11] = stat_event_in[11] | ev_prio_wr;
    cnt_inc[12] = stat_event_in[12] | ev_nprio_rd;
    cnt_inc[13] = stat_event_in[13] | ev_nprio_wr;
  end

  // Writing zero clears; a nonzero write presets, which helps test software
  genvar gi;
  generate
    for (gi = 0; gi < `MLRB_NUM_EVENTS; gi = gi + 1) begin : g_cnt
      // Sized copy of the index keeps the select compare at five bits
      localparam integer SEL_I  = gi;
      localparam [4:0]   SEL    = SEL_I[4:0];
      wire               wr_hit = msg_cnt && msg_write_in && (cnt_sel == SEL);
      mlrb_event_counter u_cnt (
        .ref_clk_in   (ref_clk_in),
        .srst_in      (srst_in),
        .inc_in       (cnt_inc[gi]),
        .clr_in       (wr_hit && (msg_wdata_in == 16'h0000)), // [R08]
        .load_in      (wr_hit && (msg_wdata_in != 16'h0000)),
        .load_data_in (msg_wdata_in),
        .count_out    (cnt_val[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Route capture and buffer usage
  // ==========================================================================
  // Latest route overwrites; drop 1 sits in the high byte of the first word [R18]
  integer ri;
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (ri = 0; ri < 4; ri = ri + 1) begin
        route_reg[ri] <= 16'h0000;
      end
      bufuse_reg <= 16'h0000;
    end else begin
      if (route_valid_in) begin
        route_reg[0] <= route_drops_in[63:48]; // [R18]
        route_reg[1] <= route_drops_in[47:32];
        route_reg[2] <= route_drops_in[31:16];
        route_reg[3] <= route_drops_in[15:0];
      end
      bufuse_reg <= buffers_in_use_in; // [R19]
    end
  end

  // ==========================================================================
  // Mailbox writes
  // ==========================================================================
  // Network write wins over a rack write to any word in the same cycle;
  // the rack scan is periodic and will simply refresh on its next pass
  always @(posedge ref_clk_in) begin
    if (msg_mbox && msg_write_in) begin
      mbox_mem[mbox_idx(msg_addr_in)] <= msg_wdata_in; // [R04] [R07]
    end else if (rack_hit && rack_write_in) begin
      mbox_mem[mbox_idx(rack_reg_no)] <= rack_wdata_in; // [R06]
    end
  end

  // ==========================================================================
  // Statistics words by name
  // ==========================================================================
  // Receive side of the legacy peer protocol
  wire [15:0] eth_cmd_reply_rx_count     = cnt_val[0];
  wire [15:0] eth_rx_no_buffer_count     = cnt_val[1];
  wire [15:0] eth_retry_rx_count         = cnt_val[2];

  // Local generation and transmission
  wire [15:0] eth_local_gen_count        = cnt_val[3];
  wire [15:0] eth_gen_fail_count         = cnt_val[4];
  wire [15:0] eth_tx_ok_count            = cnt_val[5];
  wire [15:0] eth_tx_fail_count          = cnt_val[6];
  wire [15:0] eth_tx_retry_count         = cnt_val[7];

  // Discards for a bad drop or route
  wire [15:0] eth_bad_route_count        = cnt_val[8];

  // Illegal operations on local registers
  wire [15:0] eth_illegal_op_count       = cnt_val[9];

  // Local reads and writes, by priority
  wire [15:0] eth_prio_read_count        = cnt_val[10];
  wire [15:0] eth_prio_write_count       = cnt_val[11];
  wire [15:0] eth_nonprio_read_count     = cnt_val[12];
  wire [15:0] eth_nonprio_write_count    = cnt_val[13];

  // Foreign packets and packet totals
  wire [15:0] eth_foreign_pkt_rx_count   = cnt_val[14];
  wire [15:0] eth_pkt_tx_count           = cnt_val[15];
  wire [15:0] eth_pkt_rx_count           = cnt_val[16];

  // Collisions
  wire [15:0] eth_collision_count        = cnt_val[17];
  wire [15:0] eth_excess_collision_count = cnt_val[18];

  // Receive errors
  wire [15:0] eth_crc_error_count        = cnt_val[19];
  wire [15:0] eth_framing_error_count    = cnt_val[20];

  // Sequence negative acknowledges sent
  wire [15:0] eth_seq_nak_count          = cnt_val[21];

  // Last received route, drop 1 in the high byte of the first word
  wire [15:0] eth_last_route_drops_1_2   = route_reg[0];
  wire [15:0] eth_last_route_drops_3_4   = route_reg[1];
  wire [15:0] eth_last_route_drops_5_6   = route_reg[2];
  wire [15:0] eth_last_route_drops_7_8   = route_reg[3];

  // Buffer usage, sampled every cycle
  wire [15:0] eth_buffers_in_use         = bufuse_reg;

  // ==========================================================================
  // Read mux for the network side
  // ==========================================================================
  // Full register number decode; the answer stage gates it to stat reads
  reg [15:0] stat_rd;
  always @* begin
    stat_rd = 16'h0000;
    case (msg_addr_in)
      // Event counters
      `MLRB_ETH_CMD_REPLY_RX_COUNT: stat_rd = eth_cmd_reply_rx_count; // [R09]
      `MLRB_ETH_RX_NO_BUFFER_COUNT: stat_rd = eth_rx_no_buffer_count; // [R09]
      `MLRB_ETH_RETRY_RX_COUNT: stat_rd = eth_retry_rx_count; // [R09]
      `MLRB_ETH_LOCAL_GEN_COUNT: stat_rd = eth_local_gen_count; // [R10]
      `MLRB_ETH_GEN_FAIL_COUNT: stat_rd = eth_gen_fail_count; // [R10]
      `MLRB_ETH_TX_OK_COUNT: stat_rd = eth_tx_ok_count; // [R10]
      `MLRB_ETH_TX_FAIL_COUNT: stat_rd = eth_tx_fail_count; // [R10]
      `MLRB_ETH_TX_RETRY_COUNT: stat_rd = eth_tx_retry_count; // [R10]
      `MLRB_ETH_BAD_ROUTE_COUNT: stat_rd = eth_bad_route_count; // [R11]
      `MLRB_ETH_ILLEGAL_OP_COUNT: stat_rd = eth_illegal_op_count; // [R12]
      `MLRB_ETH_PRIO_READ_COUNT: stat_rd = eth_prio_read_count; // [R13]
      `MLRB_ETH_PRIO_WRITE_COUNT: stat_rd = eth_prio_write_count; // [R13]
      `MLRB_ETH_NONPRIO_READ_COUNT: stat_rd = eth_nonprio_read_count; // [R13]
      `MLRB_ETH_NONPRIO_WRITE_COUNT: stat_rd = eth_nonprio_write_count; // [R13]
      `MLRB_ETH_FOREIGN_PKT_RX_COUNT: stat_rd = eth_foreign_pkt_rx_count; // [R14]
      `MLRB_ETH_PKT_TX_COUNT: stat_rd = eth_pkt_tx_count; // [R14]
      `MLRB_ETH_PKT_RX_COUNT: stat_rd = eth_pkt_rx_count; // [R14]
      `MLRB_ETH_COLLISION_COUNT: stat_rd = eth_collision_count; // [R15]
      `MLRB_ETH_EXCESS_COLLISION_COUNT: stat_rd = eth_excess_collision_count; // [R15]
      `MLRB_ETH_CRC_ERROR_COUNT: stat_rd = eth_crc_error_count; // [R16]
      `MLRB_ETH_FRAMING_ERROR_COUNT: stat_rd = eth_framing_error_count; // [R16]
      `MLRB_ETH_SEQ_NAK_COUNT: stat_rd = eth_seq_nak_count; // [R17]
      // Reserved words read as zero
      `MLRB_ETH_RESERVED_A, `MLRB_ETH_RESERVED_B, `MLRB_ETH_RESERVED_C,
      `MLRB_ETH_RESERVED_D, `MLRB_ETH_RESERVED_E: stat_rd = 16'h0000; // [R20]
      // Route and buffer status
      `MLRB_ETH_LAST_ROUTE_DROPS_1_2: stat_rd = eth_last_route_drops_1_2; // [R18]
      `MLRB_ETH_LAST_ROUTE_DROPS_3_4: stat_rd = eth_last_route_drops_3_4; // [R18]
      `MLRB_ETH_LAST_ROUTE_DROPS_5_6: stat_rd = eth_last_route_drops_5_6; // [R18]
      `MLRB_ETH_LAST_ROUTE_DROPS_7_8: stat_rd = eth_last_route_drops_7_8; // [R18]
      `MLRB_BUFUSE: stat_rd = eth_buffers_in_use; // [R19]
      default: stat_rd = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Answer registers; all outputs come from flip-flops
  // ==========================================================================
  // Mailbox contents are not reset, so reads before a write return memory state
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      msg_ack_out    <= 1'b0;
      msg_err_out    <= 1'b0;
      msg_route_out  <= 1'b0;
      msg_rdata_out  <= 16'h0000;
    end else begin
      msg_ack_out   <= msg_local && !msg_illegal;
      msg_err_out   <= msg_illegal; // [R12]
      msg_route_out <= msg_valid_in && !msg_local; // [R01]
      if (msg_mbox && !msg_write_in) begin
        msg_rdata_out <= mbox_mem[mbox_idx(msg_addr_in)];
      end else if (msg_stat && !msg_write_in) begin
        msg_rdata_out <= stat_rd;
      end else begin
        msg_rdata_out <= 16'h0000;
      end
    end
  end

  // ==========================================================================
  // Rack answer
  // ==========================================================================
  // A refused access answers zero data so stale words never leak out
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      rack_ack_out   <= 1'b0;
      rack_err_out   <= 1'b0;
      rack_rdata_out <= 16'h0000;
    end else begin
      rack_ack_out <= rack_hit;
      rack_err_out <= rack_valid_in && !rack_hit; // [R02] [R07]
      if (rack_hit && !rack_write_in) begin
        rack_rdata_out <= mbox_mem[mbox_idx(rack_reg_no)]; // [R05]
      end else begin
        rack_rdata_out <= 16'h0000;
      end
    end
  end
endmodule

// >>> dv/mlrb_client_model.sv
// Network client model issuing one-cycle requests to the local register bank
`timescale 1ns/1ps
module mlrb_client_model (
  input  wire        ref_clk_in,
  input  wire        ack_in,
  input  wire        err_in,
  input  wire        route_in,
  input  wire [15:0] rdata_in,
  output reg         valid_out,
  output reg  [7:0]  index_out,
  output reg         write_out,
  output reg         prio_out,
  output reg  [11:0] addr_out,
  output reg  [15:0] wdata_out
);
  initial {valid_out, index_out, write_out, prio_out, addr_out, wdata_out} = 39'h00_0000_0000;
  // ========================================
  // Request task
  // Strobe lasts one edge; released address and data lines flip so stale values never match
  task req(input [7:0] idx, input w, input p, input [11:0] a, input [15:0] d, output [2:0] rsp, output [15:0] rd);
    begin
      @(negedge ref_clk_in);
      {valid_out, index_out, write_out, prio_out, addr_out, wdata_out} <= {1'b1, idx, w, p, a, d};
      @(negedge ref_clk_in);
      valid_out <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
      rsp = {ack_in, err_in, route_in};
      rd  = rdata_in;
    end
  endtask
endmodule

// >>> dv/mlrb_register_bank_monitor.sv
// Concurrent checks on the bank's request and answer ports
`timescale 1ns/1ps
module mlrb_register_bank_monitor (
  input wire        ref_clk_in,
  input wire        srst_in,
  input wire        msg_valid_in,
  input wire [7:0]  msg_index_in,
  input wire        msg_write_in,
  input wire [11:0] msg_addr_in,
  input wire        msg_ack_out,
  input wire        msg_err_out,
  input wire        msg_route_out,
  input wire [15:0] msg_rdata_out,
  input wire        io_module_mode_in,
  input wire        rack_valid_in,
  input wire        rack_input_space_in,
  input wire [11:0] rack_offset_in,
  input wire        rack_ack_out,
  input wire        rack_err_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // ========================================
  // Answer checks
  wire loc = msg_valid_in && (msg_index_in == 8'hff);
  a_local_read_ack : assert property (loc && !msg_write_in && msg_addr_in inside {[12'h0001:12'h0820]}
    |=> msg_ack_out) else $error("local read not acked");
  a_route_other : assert property (msg_valid_in && msg_index_in != 8'hff |=> msg_route_out)
    else $error("foreign index not routed");
  a_one_answer : assert property ($onehot0({msg_ack_out, msg_err_out, msg_route_out}))
    else $error("more than one answer");
  a_quiet_idle : assert property (!msg_valid_in |=> !(msg_ack_out || msg_err_out || msg_route_out))
    else $error("answer without request");
  a_unmapped_err : assert property (loc && (msg_addr_in == 12'h0000 || msg_addr_in > 12'h0820) |=> msg_err_out)
    else $error("unmapped number not refused");
  a_ro_write_err : assert property (loc && msg_write_in && msg_addr_in inside {[12'h081c:12'h0820]}
    |=> msg_err_out) else $error("read-only write not refused");
  a_rsvd_zero : assert property (loc && !msg_write_in && msg_addr_in inside {[12'h0817:12'h081b]}
    |=> msg_ack_out && msg_rdata_out == 16'h0000) else $error("reserved read not zero");
  // Rack window exists only in I/O module mode
  a_option_no_rack : assert property (rack_valid_in && !io_module_mode_in |=> rack_err_out && !rack_ack_out)
    else $error("rack access in option mode");
  a_rack_window : assert property (rack_valid_in && io_module_mode_in && !rack_input_space_in
    && rack_offset_in < 12'h0040 |=> rack_ack_out) else $error("rack window access refused");
  a_rack_beyond : assert property (rack_valid_in && rack_offset_in >= 12'h0040 |=> rack_err_out)
    else $error("rack offset beyond window");
endmodule
bind mlrb_register_bank mlrb_register_bank_monitor u_mlrb_register_bank_monitor (.*);

// >>> dv/mlrb_register_bank_tb.sv
// Self-checking bench for the local register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module mlrb_register_bank_tb;
  localparam [63:0] ROUTE = 64'h0102_0304_0506_0708;
  reg        ref_clk_in = 0, srst_in = 1, io_mode = 1, rk_v = 0, rk_w = 0, rk_s = 0, rt_v = 0;
  reg [11:0] rk_o = 0;
  reg [15:0] rk_d = 0, bufuse = 0, val;
  reg [21:0] ev = 0;
  reg [2:0]  rsp;
  wire       mv, mw, mp, ack, err, rte, rk_ack, rk_err;
  wire [7:0] mi;
  wire [11:0] ma;
  wire [15:0] md, rd, rk_rd;
  int        num_errors = 0, compares = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  mlrb_register_bank u_mlrb_register_bank (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .msg_valid_in(mv),
    .msg_index_in(mi), .msg_write_in(mw), .msg_priority_in(mp), .msg_addr_in(ma), .msg_wdata_in(md), .msg_ack_out(ack),
    .msg_err_out(err), .msg_route_out(rte), .msg_rdata_out(rd), .io_module_mode_in(io_mode), .rack_valid_in(rk_v),
    .rack_write_in(rk_w), .rack_input_space_in(rk_s), .rack_offset_in(rk_o), .rack_wdata_in(rk_d), .rack_ack_out(rk_ack),
    .rack_err_out(rk_err), .rack_rdata_out(rk_rd), .stat_event_in(ev), .route_valid_in(rt_v),
    .route_drops_in(rt_v ? ROUTE : ~ROUTE), .buffers_in_use_in(bufuse));
  mlrb_client_model u_mlrb_client_model (.ref_clk_in(ref_clk_in), .ack_in(ack), .err_in(err), .route_in(rte),
    .rdata_in(rd), .valid_out(mv), .index_out(mi), .write_out(mw), .prio_out(mp), .addr_out(ma), .wdata_out(md));
  // ========================================
  // Access helpers; priority reads keep the non-priority counters still
  task wr(input p, input [11:0] a, input [15:0] d);
    u_mlrb_client_model.req(8'hff, 1'b1, p, a, d, rsp, val);
  endtask
  task rdp(input [11:0] a);
    u_mlrb_client_model.req(8'hff, 1'b0, 1'b1, a, 16'h0000, rsp, val);
  endtask
  task rack(input w, input s, input [11:0] o, input [15:0] d);
    @(negedge ref_clk_in) {rk_v, rk_w, rk_s, rk_o, rk_d} = {1'b1, w, s, o, d};
    @(negedge ref_clk_in) {rk_v, rk_o, rk_d} = {1'b0, ~o, ~d};
    {rsp, val} = {rk_ack, rk_err, 1'b0, rk_rd};
  endtask
  task pulse(input [21:0] b, input int n);
    repeat (n) begin
      @(negedge ref_clk_in) ev = b;
      @(negedge ref_clk_in) ev = 22'h00_0000;
    end
  endtask
  // ========================================
  // Scenarios
  task t_mailbox;
    wr(1, 12'h080e, 16'h0000);
    wr(1, 12'h080d, 16'h0000);
    wr(0, 12'h0001, 16'h1234);
    wr(0, 12'h0800, 16'habcd);
    u_mlrb_client_model.req(8'hff, 1'b0, 1'b0, 12'h0800, 16'h0000, rsp, val);
    `CHK(val, 16'habcd)
    rdp(12'h0001); `CHK(val, 16'h1234)
    rdp(12'h080e); `CHK(val, 16'h0002)
    rdp(12'h080d); `CHK(val, 16'h0001)
  endtask
  task t_rack;
    rack(1, 0, 12'h0000, 16'h5a5a); `CHK(rsp, 3'b100)
    rdp(12'h0001); `CHK(val, 16'h5a5a)
    wr(1, 12'h0021, 16'h3333);
    rack(0, 1, 12'h0000, 16'h0000); `CHK(val, 16'h3333)
    rack(1, 1, 12'h0000, 16'h0000); `CHK(rsp, 3'b010)
    rack(0, 0, 12'h0040, 16'h0000); `CHK(rsp, 3'b010)
    wr(1, 12'h0041, 16'h7777);
    rdp(12'h0041); `CHK(val, 16'h7777)
    io_mode = 0;
    rack(0, 0, 12'h0000, 16'h0000); `CHK(rsp, 3'b010)
    io_mode = 1;
  endtask
  task t_counters;
    for (int k = 0; k < 22; k++) if (k < 9 || k > 13) begin
      wr(1, 12'(12'h0801 + k), 16'h0000);
      pulse(22'h1 << k, 3);
      rdp(12'(12'h0801 + k)); `CHK(val, 16'h0003)
    end
    wr(1, 12'h0801, 16'hffff);
    pulse(22'h00_0001, 1);
    rdp(12'h0801); `CHK(val, 16'h0000)
    wr(1, 12'h080a, 16'h0000);
    rdp(12'h0000); `CHK(rsp, 3'b010)
    wr(1, 12'h081c, 16'h1111); `CHK(rsp, 3'b010)
    rdp(12'h080a); `CHK(val, 16'h0002)
  endtask
  task t_misc;
    @(negedge ref_clk_in) rt_v = 1;
    @(negedge ref_clk_in) rt_v = 0;
    for (int n = 0; n < 4; n++) begin
      rdp(12'(12'h081c + n)); `CHK(val, ROUTE[63 - 16 * n -: 16])
    end
    bufuse = 16'h0007;
    rdp(12'h0820); `CHK(val, 16'h0007)
    wr(1, 12'h0817, 16'h1111); `CHK(rsp, 3'b100)
    rdp(12'h0817); `CHK(val, 16'h0000)
    u_mlrb_client_model.req(8'h01, 1'b0, 1'b0, 12'h0001, 16'h0000, rsp, val); `CHK(rsp, 3'b001)
  endtask
  task stop_test;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset for two cycles, release off the sampling edge
  initial begin
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in) srst_in = 0;
    rdp(12'h0810); `CHK(val, 16'h0000)
    t_mailbox;
    t_rack;
    t_counters;
    t_misc;
    stop_test;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
endmodule
